// [logic/jcp_pkg.sv]
// Package with the constants and carrier types of the test-port configuration loader.
package jcp_pkg;
    // Instruction register width and opcodes; the values are this design's own.
    localparam int IR_W = 4;
    localparam logic [3:0] OP_EXTEST_UNUSED = 4'h0;
    localparam logic [3:0] OP_IDCODE = 4'h1;
    localparam logic [3:0] OP_SAMPLE = 4'h2;
    localparam logic [3:0] OP_PROGRAM = 4'h3;
    localparam logic [3:0] OP_CHECK_STATUS = 4'h4;
    localparam logic [3:0] OP_CONFIG_IO = 4'h5;
    localparam logic [3:0] OP_PULSE_CONFIG = 4'h6;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    // Capture pattern of the instruction register, two low bits fixed as usual.
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // Width of the shared data shift path, sized for the identification word.
    localparam int SH_W = 32;
    // Test clock cycles of initialization after the last bitstream bit.
    localparam int INIT_CYCLES = 1094;
    localparam int INIT_W = 11;
    localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);
    // Synchroniser depth for pins and cross-domain toggles.
    localparam int SYNC_STAGES = 3;

    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PAUSE_DR,
        TS_EX2_DR, TS_UPD_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PAUSE_IR,
        TS_EX2_IR, TS_UPD_IR
    } jcp_tap_t;

    typedef enum logic [1:0] {
        CP_IDLE, CP_LOAD, CP_INIT, CP_DONE
    } jcp_load_t;

    typedef enum logic [1:0] {
        CS_UNCONF, CS_CONFIGURING, CS_USER, CS_INTERRUPTED
    } jcp_cfg_t;

    // Events from the test-clock side, each carried as a toggle.
    typedef struct packed {
        logic start;
        logic done;
        logic abort;
        logic pulse;
    } jcp_evt_t;

    // Filtered board-level configuration pins.
    typedef struct packed {
        logic reconfigure_request_n;
        logic chip_enable_in_n;
        logic global_clear_n;
        logic global_output_enable;
    } jcp_pins_t;
endpackage : jcp_pkg

// [logic/jcp_config_port.sv]
// Test-port configuration loader: TAP, bitstream loading and configuration state.
// Operation
// - Bypass is one stage, no side effect.
// - Program data returns on TDO one cycle later.
// - 1094 extra test clocks finish initialization.
// - Done flag rises on successful configuration.
// - Test pins always act as test pins.
// - Bypass, idcode, sample run during configuration.
// - I/O setup aborts configuration, drives buffers.
// - Global clear and enable ignored by port.
// - Capture on rising, launch on falling, else tri-state.
// - Test-port configuration preempts other schemes.
// - User I/O high impedance while configuring.
`timescale 1ns/1ps
`default_nettype none
module jcp_config_port #(
    parameter int IO_W = 8,
    parameter int BITSTREAM_BITS = 1024,
    parameter logic [31:0] ID_CODE = 32'h0000_1001 // Arbitrary value.
) (
    // System side.
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Test access port.
    input wire logic tck_in,
    input wire logic trst_n_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // Configuration pins.
    input wire logic reconfigure_request_n_in,
    input wire logic chip_enable_in_n_in,
    input wire logic global_clear_n_in,
    input wire logic global_output_enable_in,
    output logic config_done_flag_out,
    output logic config_error_flag_n_out,
    output logic chain_enable_out_n_out,
    output logic other_scheme_abort_out,
    // User I/O.
    input wire logic [IO_W-1:0] core_io_in,
    input wire logic [IO_W-1:0] core_io_oe_in,
    input wire logic [IO_W-1:0] user_io_pin_in,
    output logic [IO_W-1:0] user_io_out,
    output logic [IO_W-1:0] user_io_oe_out
);
    localparam int BSR_W = IO_W + 2;

    if (IO_W < 1 || BSR_W > jcp_pkg::SH_W || BITSTREAM_BITS < 1) begin : g_bad_params
        $error("jcp_config_port: unsupported parameters");
    end

    // Instructions outside the set allowed during loading fall back to bypass.
    function automatic logic [3:0] jcp_decode(input logic [3:0] op, input logic loading);
        logic ok;
        ok = (op == jcp_pkg::OP_BYPASS) || (op == jcp_pkg::OP_IDCODE) ||
             (op == jcp_pkg::OP_SAMPLE) || (op == jcp_pkg::OP_CONFIG_IO) ||
             (op == jcp_pkg::OP_PROGRAM);
        return (loading && !ok) ? jcp_pkg::OP_BYPASS : op;
    endfunction : jcp_decode

    // Test-clock domain; the global pins only reach it through sampling.
    logic tck_rst_n;
    assign tck_rst_n = trst_n_in & rstn_in;

    jcp_pkg::jcp_tap_t tap, next_tap;
    jcp_pkg::jcp_load_t ld, next_ld;
    logic [3:0] ir_sh, next_ir_sh, ir, next_ir;
    logic [jcp_pkg::SH_W-1:0] dr_sh, next_dr_sh;
    logic [IO_W-1:0] bsr_upd, next_bsr_upd;
    logic bypass_bit, next_bypass_bit;
    logic prog_bit, next_prog_bit;
    logic [31:0] bit_cnt, next_bit_cnt;
    logic [jcp_pkg::INIT_W-1:0] init_cnt, next_init_cnt;
    jcp_pkg::jcp_evt_t evt, next_evt;
    logic [2:0] done_sync;
    logic done_seen, next_done_seen;
    logic [3:0] op;

    assign op = jcp_decode(ir, ld == jcp_pkg::CP_LOAD || ld == jcp_pkg::CP_INIT);

    always_comb begin
        next_tap = tap;
        unique case (tap)
            jcp_pkg::TS_RESET: next_tap = tms_in ? jcp_pkg::TS_RESET : jcp_pkg::TS_IDLE;
            jcp_pkg::TS_IDLE: next_tap = tms_in ? jcp_pkg::TS_SEL_DR : jcp_pkg::TS_IDLE;
            jcp_pkg::TS_SEL_DR: next_tap = tms_in ? jcp_pkg::TS_SEL_IR : jcp_pkg::TS_CAP_DR;
            jcp_pkg::TS_CAP_DR: next_tap = tms_in ? jcp_pkg::TS_EX1_DR : jcp_pkg::TS_SH_DR;
            jcp_pkg::TS_SH_DR: next_tap = tms_in ? jcp_pkg::TS_EX1_DR : jcp_pkg::TS_SH_DR;
            jcp_pkg::TS_EX1_DR: next_tap = tms_in ? jcp_pkg::TS_UPD_DR : jcp_pkg::TS_PAUSE_DR;
            jcp_pkg::TS_PAUSE_DR: next_tap = tms_in ? jcp_pkg::TS_EX2_DR : jcp_pkg::TS_PAUSE_DR;
            jcp_pkg::TS_EX2_DR: next_tap = tms_in ? jcp_pkg::TS_UPD_DR : jcp_pkg::TS_SH_DR;
            jcp_pkg::TS_UPD_DR: next_tap = tms_in ? jcp_pkg::TS_SEL_DR : jcp_pkg::TS_IDLE;
            jcp_pkg::TS_SEL_IR: next_tap = tms_in ? jcp_pkg::TS_RESET : jcp_pkg::TS_CAP_IR;
            jcp_pkg::TS_CAP_IR: next_tap = tms_in ? jcp_pkg::TS_EX1_IR : jcp_pkg::TS_SH_IR;
            jcp_pkg::TS_SH_IR: next_tap = tms_in ? jcp_pkg::TS_EX1_IR : jcp_pkg::TS_SH_IR;
            jcp_pkg::TS_EX1_IR: next_tap = tms_in ? jcp_pkg::TS_UPD_IR : jcp_pkg::TS_PAUSE_IR;
            jcp_pkg::TS_PAUSE_IR: next_tap = tms_in ? jcp_pkg::TS_EX2_IR : jcp_pkg::TS_PAUSE_IR;
            jcp_pkg::TS_EX2_IR: next_tap = tms_in ? jcp_pkg::TS_UPD_IR : jcp_pkg::TS_SH_IR;
            jcp_pkg::TS_UPD_IR: next_tap = tms_in ? jcp_pkg::TS_SEL_DR : jcp_pkg::TS_IDLE;
        endcase
    end

    always_comb begin
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_dr_sh = dr_sh;
        next_bsr_upd = bsr_upd;
        next_bypass_bit = bypass_bit;
        next_prog_bit = prog_bit;
        next_bit_cnt = bit_cnt;
        next_init_cnt = init_cnt;
        next_ld = ld;
        next_evt = evt;
        next_done_seen = (done_sync[2] == done_sync[1]) ? done_sync[2] : done_seen;
        unique case (tap)
            jcp_pkg::TS_RESET: next_ir = jcp_pkg::OP_IDCODE;
            jcp_pkg::TS_CAP_IR: next_ir_sh = jcp_pkg::IR_CAPTURE;
            jcp_pkg::TS_SH_IR: next_ir_sh = {tdi_in, ir_sh[3:1]};
            jcp_pkg::TS_UPD_IR: next_ir = ir_sh;
            jcp_pkg::TS_CAP_DR: begin
                next_bypass_bit = 1'b0;
                if (op == jcp_pkg::OP_IDCODE) begin
                    next_dr_sh = ID_CODE;
                end else if (op == jcp_pkg::OP_CHECK_STATUS) begin
                    next_dr_sh = {31'h0000_0000, done_seen};
                end else if (op == jcp_pkg::OP_SAMPLE || op == jcp_pkg::OP_CONFIG_IO) begin
                    next_dr_sh = '0;
                    next_dr_sh[BSR_W-1:0] = {global_output_enable_in, global_clear_n_in,
                                             user_io_pin_in};
                end
            end
            jcp_pkg::TS_SH_DR: begin
                next_bypass_bit = tdi_in;
                next_prog_bit = tdi_in;
                if (op == jcp_pkg::OP_IDCODE || op == jcp_pkg::OP_CHECK_STATUS) begin
                    next_dr_sh = {tdi_in, dr_sh[jcp_pkg::SH_W-1:1]};
                end else if (op == jcp_pkg::OP_SAMPLE || op == jcp_pkg::OP_CONFIG_IO) begin
                    next_dr_sh[BSR_W-1:0] = {tdi_in, dr_sh[BSR_W-1:1]};
                end
            end
            jcp_pkg::TS_UPD_DR: begin
                if (op == jcp_pkg::OP_CONFIG_IO) begin
                    next_bsr_upd = dr_sh[IO_W-1:0];
                end
            end
            default: ;
        endcase
        // Bitstream and initialization counting.
        if (ld == jcp_pkg::CP_LOAD && tap == jcp_pkg::TS_SH_DR && op == jcp_pkg::OP_PROGRAM) begin
            next_bit_cnt = bit_cnt + 32'h0000_0001;
            if (bit_cnt == 32'(BITSTREAM_BITS - 1)) begin
                next_ld = jcp_pkg::CP_INIT;
                next_init_cnt = '0;
            end
        end else if (ld == jcp_pkg::CP_INIT) begin
            next_init_cnt = init_cnt + 11'h001;
            if (init_cnt == jcp_pkg::INIT_LAST) begin
                next_ld = jcp_pkg::CP_DONE;
                next_evt.done = ~evt.done;
            end
        end
        if (tap == jcp_pkg::TS_UPD_IR) begin
            if (ir_sh == jcp_pkg::OP_PROGRAM) begin
                next_ld = jcp_pkg::CP_LOAD;
                next_bit_cnt = '0;
                next_evt.start = ~evt.start;
            end else if (ir_sh == jcp_pkg::OP_CONFIG_IO) begin
                next_ld = jcp_pkg::CP_IDLE;
                next_evt.abort = ~evt.abort;
            end else if (ir_sh == jcp_pkg::OP_PULSE_CONFIG) begin
                next_ld = jcp_pkg::CP_IDLE;
                next_evt.pulse = ~evt.pulse;
            end
        end
    end

    always_ff @(posedge tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tap <= jcp_pkg::TS_RESET;
            ld <= jcp_pkg::CP_IDLE;
            ir_sh <= '0;
            ir <= jcp_pkg::OP_IDCODE;
            dr_sh <= '0;
            bsr_upd <= '0;
            bypass_bit <= 1'b0;
            prog_bit <= 1'b0;
            bit_cnt <= '0;
            init_cnt <= '0;
            done_sync <= '0;
            done_seen <= 1'b0;
        end else begin
            tap <= next_tap;
            ld <= next_ld;
            ir_sh <= next_ir_sh;
            ir <= next_ir;
            dr_sh <= next_dr_sh;
            bsr_upd <= next_bsr_upd;
            bypass_bit <= next_bypass_bit;
            prog_bit <= next_prog_bit;
            bit_cnt <= next_bit_cnt;
            init_cnt <= next_init_cnt;
            done_sync <= {done_sync[1:0], config_done_flag_out};
            done_seen <= next_done_seen;
        end
    end

    // Event toggles ignore the test reset, which would otherwise fake events on the system side.
    always_ff @(posedge tck_in or negedge rstn_in) begin
        if (!rstn_in) begin
            evt <= '0;
        end else begin
            evt <= next_evt;
        end
    end

    // Output launched on the falling edge so the host samples a stable bit.
    logic next_tdo, next_tdo_oe;
    always_comb begin
        next_tdo_oe = (tap == jcp_pkg::TS_SH_DR) || (tap == jcp_pkg::TS_SH_IR);
        if (tap == jcp_pkg::TS_SH_IR) begin
            next_tdo = ir_sh[0];
        end else if (op == jcp_pkg::OP_PROGRAM) begin
            next_tdo = prog_bit;
        end else if (op == jcp_pkg::OP_IDCODE || op == jcp_pkg::OP_CHECK_STATUS ||
                     op == jcp_pkg::OP_SAMPLE || op == jcp_pkg::OP_CONFIG_IO) begin
            next_tdo = dr_sh[0];
        end else begin
            next_tdo = bypass_bit;
        end
    end

    always_ff @(negedge tck_in or negedge tck_rst_n) begin
        if (!tck_rst_n) begin
            tdo_out <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else begin
            tdo_out <= next_tdo;
            tdo_oe_out <= next_tdo_oe;
        end
    end

    // System domain: pins and toggles each pass three stages, agreed by the last two.
    localparam int SV_W = 8;
    logic [SV_W-1:0] raw, s1, s2, s3, filt, next_filt;
    jcp_pkg::jcp_evt_t evt_f, evt_prev;
    jcp_pkg::jcp_pins_t pins;
    assign raw = {evt, reconfigure_request_n_in, chip_enable_in_n_in, global_clear_n_in,
                  global_output_enable_in};
    assign evt_f = filt[7:4];
    assign pins = filt[3:0];

    genvar gi;
    generate
        for (gi = 0; gi < SV_W; gi++) begin : g_filt
            assign next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
        end
    endgenerate

    jcp_pkg::jcp_cfg_t cs, next_cs;
    logic next_done, next_err_n, next_ceo_n, next_abort;
    always_comb begin
        next_cs = cs;
        next_err_n = config_error_flag_n_out;
        if (!pins.reconfigure_request_n || (evt_f.pulse != evt_prev.pulse)) begin
            next_cs = jcp_pkg::CS_UNCONF;
            next_err_n = 1'b1;
        end else if (evt_f.abort != evt_prev.abort) begin
            next_cs = jcp_pkg::CS_INTERRUPTED;
        end else if (evt_f.start != evt_prev.start) begin
            next_cs = jcp_pkg::CS_CONFIGURING;
            next_err_n = 1'b1;
        end else if (evt_f.done != evt_prev.done && cs == jcp_pkg::CS_CONFIGURING) begin
            // A device left disabled by its chip enable never enters user mode.
            if (!pins.chip_enable_in_n) begin
                next_cs = jcp_pkg::CS_USER;
            end else begin
                next_cs = jcp_pkg::CS_UNCONF;
                next_err_n = 1'b0;
            end
        end
        next_done = (next_cs == jcp_pkg::CS_USER);
        next_ceo_n = (next_cs != jcp_pkg::CS_USER);
        next_abort = (evt_f.start != evt_prev.start);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1 <= 8'h0c;
            s2 <= 8'h0c;
            s3 <= 8'h0c;
            filt <= 8'h0c;
            evt_prev <= '0;
            cs <= jcp_pkg::CS_UNCONF;
            config_done_flag_out <= 1'b0;
            config_error_flag_n_out <= 1'b1;
            chain_enable_out_n_out <= 1'b1;
            other_scheme_abort_out <= 1'b0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            evt_prev <= evt_f;
            cs <= next_cs;
            config_done_flag_out <= next_done;
            config_error_flag_n_out <= next_err_n;
            chain_enable_out_n_out <= next_ceo_n;
            other_scheme_abort_out <= next_abort;
        end
    end

    // User pins float unless configured or set up through the port.
    always_comb begin
        unique case (cs)
            jcp_pkg::CS_USER: begin
                user_io_out = core_io_in;
                user_io_oe_out = core_io_oe_in;
            end
            jcp_pkg::CS_INTERRUPTED: begin
                user_io_out = bsr_upd;
                user_io_oe_out = '1;
            end
            default: begin
                user_io_out = '0;
                user_io_oe_out = '0;
            end
        endcase
    end
endmodule : jcp_config_port
`default_nettype wire

// [verification/jcp_port_chk_sva.sv]
// Port-level assertions for the test-port configuration loader.
`timescale 1ns/1ps
`default_nettype none
module jcp_port_chk #(
    parameter int IO_W = 8
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Watched ports.
    input wire logic tck_in,
    input wire logic tdo_out,
    input wire logic reconfigure_request_n_in,
    input wire logic chip_enable_in_n_in,
    input wire logic config_done_flag_out,
    input wire logic config_error_flag_n_out,
    input wire logic chain_enable_out_n_out,
    input wire logic other_scheme_abort_out,
    input wire logic [IO_W-1:0] user_io_oe_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    tdo_hold_a: assert property (tck_in && $past(tck_in) |-> $stable(tdo_out))
        else $error("tdo moved while tck was high");
    io_float_a: assert property (other_scheme_abort_out |-> ##2 (user_io_oe_out == '0) [*4])
        else $error("user io driven during load");
    abort_pulse_a: assert property (other_scheme_abort_out |=> !other_scheme_abort_out)
        else $error("abort pulse too long");
    start_clear_a: assert property (other_scheme_abort_out |-> ##[0:2] !config_done_flag_out)
        else $error("done kept after a new load");
    pin_reconf_a: assert property (!reconfigure_request_n_in [*6] |=> !config_done_flag_out)
        else $error("done kept while reconfigure held low");
    done_ce_a: assert property ($rose(config_done_flag_out) |-> !chip_enable_in_n_in)
        else $error("done rose with chip enable high");
    err_ce_a: assert property ($fell(config_error_flag_n_out) |-> chip_enable_in_n_in)
        else $error("error flagged with chip enable low");
    chain_out_a: assert property ($rose(config_done_flag_out) |-> ##[0:1] !chain_enable_out_n_out)
        else $error("chain enable not low when configured");
endmodule : jcp_port_chk
bind jcp_config_port jcp_port_chk #(.IO_W(IO_W)) chk_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .tck_in(tck_in), .tdo_out(tdo_out),
    .reconfigure_request_n_in(reconfigure_request_n_in),
    .chip_enable_in_n_in(chip_enable_in_n_in), .config_done_flag_out(config_done_flag_out),
    .config_error_flag_n_out(config_error_flag_n_out),
    .chain_enable_out_n_out(chain_enable_out_n_out),
    .other_scheme_abort_out(other_scheme_abort_out), .user_io_oe_out(user_io_oe_out));
`default_nettype wire

// [verification/jcp_host_model.sv]
// Host programmer model that drives the test access port of one device.
`timescale 1ns/1ps
`default_nettype none
module jcp_host_model (
    // Test access port, host side.
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    logic last_tdi = 1'b0;
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end
    // The clock runs only inside frames; idle TDI toggles so stale data is never reused.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        last_tdi = tdi;
        #80;
        tck_out = 1'b1;
        tdo = tdo_in;
        #80;
        tck_out = 1'b0;
    endtask : step
    task automatic idle(input int n);
        logic d;
        #3.3;
        for (int i = 0; i < n; i++) begin
            step(1'b0, ~last_tdi, d);
        end
    endtask : idle
    // Only this device sits on the chain, so none needs bypass and starts coincide.
    // Walks from Idle to Shift, moves n bits LSB first, updates and parks in Idle.
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic d;
        dout = '0;
        #3.3;
        step(1'b1, ~last_tdi, d);
        if (ir) begin
            step(1'b1, ~last_tdi, d);
        end
        step(1'b0, ~last_tdi, d);
        step(1'b0, ~last_tdi, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, ~last_tdi, d);
        step(1'b0, ~last_tdi, d);
    endtask : scan
endmodule : jcp_host_model
`default_nettype wire

// [verification/test_jcp_config_port.sv]
// Self-checking bench for the test-port configuration loader.
`timescale 1ns/1ps
`default_nettype none
module test_jcp_config_port;
    localparam int IO_W = 8;
    localparam int BITS = 8;
    localparam logic [31:0] ID = 32'h0000_5a31; // Arbitrary value.
    localparam int LIMIT = 60000;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic trst_n = 1'b1;
    logic recfg_n = 1'b1;
    logic ce_n = 1'b0; // Grounded enable, as a cascaded device would have.
    logic gclr_n = 1'b1;
    logic goe = 1'b1;
    logic [IO_W-1:0] core_io = '0;
    logic [IO_W-1:0] core_oe = '0;
    logic [IO_W-1:0] pins = '0;
    // The chain enable output feeds no further device here.
    // Scheme select and serial clock are tied off on the board, outside this block.
    wire logic tck, tms, tdi, tdo, tdo_oe, done, err_n, ceo_n, abort;
    wire logic [IO_W-1:0] uio, uio_oe;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int aborts = 0;
    int seed = 32'h55a2c5da;
    logic [31:0] r;
    logic [31:0] d;
    always #5 ref_clk_in = ~ref_clk_in;
    // A released output reads inverted, so a late or missing enable shows as a wrong bit.
    jcp_host_model host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
                         .tdo_in(tdo_oe ? tdo : ~tdo));
    jcp_config_port #(.IO_W(IO_W), .BITSTREAM_BITS(BITS), .ID_CODE(ID)) DUT (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .tck_in(tck), .trst_n_in(trst_n),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .reconfigure_request_n_in(recfg_n), .chip_enable_in_n_in(ce_n),
        .global_clear_n_in(gclr_n), .global_output_enable_in(goe),
        .config_done_flag_out(done), .config_error_flag_n_out(err_n),
        .chain_enable_out_n_out(ceo_n), .other_scheme_abort_out(abort),
        .core_io_in(core_io), .core_io_oe_in(core_oe), .user_io_pin_in(pins),
        .user_io_out(uio), .user_io_oe_out(uio_oe));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wref(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : wref
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (abort === 1'b1) begin
            aborts <= aborts + 1;
        end
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end
    // Starts a load and shifts a random bitstream; the echo lags by one bit.
    task automatic prog();
        int a;
        a = aborts;
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_PROGRAM), d);
        wref(20);
        chk(32'(aborts - a), 32'h1);
        chk(32'(uio_oe), 32'h0);
        r = $random(seed);
        host.scan(1'b0, BITS, r, d);
        chk(32'(d[BITS-1:1]), 32'(r[BITS-2:0]));
        chk(32'(done), 32'h0);
    endtask : prog
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        wref(2);
        host.idle(1);
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_BYPASS), d);
        chk(32'(d[3:0]), 32'(jcp_pkg::IR_CAPTURE));
        r = $random(seed);
        host.scan(1'b0, 9, r, d);
        chk(32'(d[8:0]), 32'({r[7:0], 1'b0}));
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_IDCODE), d);
        host.scan(1'b0, 32, r, d);
        chk(d, ID);
        $display("test bypass and idcode done");
        prog();
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_IDCODE), d);
        host.scan(1'b0, 32, r, d);
        chk(d, ID);
        // Rises after the last bit so far: 2 + 10 + 37; 1044 more leaves one short.
        host.idle(1044);
        wref(20);
        chk(32'(done), 32'h0);
        host.idle(1);
        wref(20);
        chk(32'({done, ceo_n}), 32'h2);
        @(posedge ref_clk_in);
        {goe, gclr_n} <= 2'h0;
        core_io <= IO_W'($random(seed));
        core_oe <= IO_W'($random(seed));
        wref(6);
        chk(32'(done), 32'h1);
        chk(32'({uio, uio_oe}), 32'({core_io, core_oe}));
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_CHECK_STATUS), d);
        host.scan(1'b0, 32, r, d);
        chk(32'(d[0]), 32'h1);
        @(posedge ref_clk_in);
        recfg_n <= 1'b0;
        wref(10);
        chk(32'(done), 32'h0);
        @(posedge ref_clk_in);
        recfg_n <= 1'b1;
        $display("test load and reconfigure done");
        @(posedge ref_clk_in);
        ce_n <= 1'b1;
        prog();
        host.idle(1100);
        wref(20);
        chk(32'({done, err_n}), 32'h0);
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_PULSE_CONFIG), d);
        wref(20);
        chk(32'({done, err_n}), 32'h1);
        @(posedge ref_clk_in);
        ce_n <= 1'b0;
        $display("test chip enable and pulse done");
        prog();
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_CONFIG_IO), d);
        wref(20);
        chk(32'(uio_oe), 32'({IO_W{1'b1}}));
        r = $random(seed);
        host.scan(1'b0, IO_W + 2, r, d);
        wref(20);
        chk(32'(uio), 32'(r[IO_W-1:0]));
        @(posedge ref_clk_in);
        {goe, gclr_n, pins} <= 10'($random(seed));
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_SAMPLE), d);
        host.scan(1'b0, IO_W + 2, r, d);
        chk(32'(d[IO_W+1:0]), 32'({goe, gclr_n, pins}));
        chk(32'(done), 32'h0);
        $display("test interrupt and sample done");
        host.scan(1'b1, 4, 32'(jcp_pkg::OP_BYPASS), d);
        @(posedge ref_clk_in);
        trst_n <= 1'b0;
        @(posedge ref_clk_in);
        trst_n <= 1'b1;
        wref(20);
        chk(32'(uio_oe), 32'({IO_W{1'b1}}));
        host.idle(1);
        host.scan(1'b0, 32, r, d);
        chk(d, ID);
        @(posedge ref_clk_in);
        rstn_in <= 1'b0;
        wref(3);
        chk(32'({tdo_oe, done, err_n, ceo_n, abort, uio_oe}), 32'h0000_0600);
        @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        wref(2);
        $display("test resets done");
        end_of_test();
    end
endmodule : test_jcp_config_port
`default_nettype wire
